// >>> rtl/cpt_pkg.sv
// constants for the compact 10-bit timer
package cpt_pkg;

   // register byte addresses
   localparam logic [7:0] ADDR_CTRL_A      = 8'h00;
   localparam logic [7:0] ADDR_CTRL_B      = 8'h04;
   localparam logic [7:0] ADDR_COUNT_LOW   = 8'h08;
   localparam logic [7:0] ADDR_COUNT_HIGH  = 8'h0C;
   localparam logic [7:0] ADDR_MATCH_LOW   = 8'h10;
   localparam logic [7:0] ADDR_MATCH_HIGH  = 8'h14;

   // timer_ctrl_a fields
   localparam int unsigned CA_PAUSE   = 7;
   localparam int unsigned CA_CKSEL   = 4;
   localparam int unsigned CA_ON      = 3;
   localparam int unsigned CA_CODE    = 0;

   // timer_ctrl_b fields
   localparam int unsigned CB_MODE    = 6;
   localparam int unsigned CB_PINF    = 4;
   localparam int unsigned CB_OIL     = 3;
   localparam int unsigned CB_INV     = 2;
   localparam int unsigned CB_SWAP    = 1;
   localparam int unsigned CB_CLRSEL  = 0;

   // reset values
   localparam logic [7:0] CTRL_A_RST  = 8'h00;
   localparam logic [7:0] CTRL_B_RST  = 8'h00;
   localparam logic [9:0] MATCH_A_RST = 10'h000;
   localparam logic [7:0] HOLD_RST    = 8'h00;

   // operating modes
   localparam logic [1:0] MODE_CMP    = 2'h0;
   localparam logic [1:0] MODE_PWM    = 2'h2;
   localparam logic [1:0] MODE_TMR    = 2'h3;

   // pin function codes
   localparam logic [1:0] PINF_00     = 2'h0;
   localparam logic [1:0] PINF_01     = 2'h1;
   localparam logic [1:0] PINF_10     = 2'h2;
   localparam logic [1:0] PINF_11     = 2'h3;

   // clock select codes
   localparam logic [2:0] CK_SYS_4    = 3'h0;
   localparam logic [2:0] CK_SYS      = 3'h1;
   localparam logic [2:0] CK_H_16     = 3'h2;
   localparam logic [2:0] CK_H_64     = 3'h3;
   localparam logic [2:0] CK_SUB_A    = 3'h4;
   localparam logic [2:0] CK_SUB_B    = 3'h5;

   // prescaler terminal masks
   localparam logic [5:0] DIV4_MASK   = 6'h03;
   localparam logic [5:0] DIV16_MASK  = 6'h0F;
   localparam logic [5:0] DIV64_MASK  = 6'h3F;

   localparam logic [9:0] COUNT_MAX   = 10'h3FF;
   localparam logic [2:0] CODE_ZERO   = 3'h0;

   // bus responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// >>> rtl/cpt_timer.sv
// compact 10-bit timer with axi4-lite register access
// Function
// - match-A low write goes to holding buffer; high write loads both bytes
// - high byte read returns directly and captures low byte into buffer
// - core is a 10-bit up-counter on the selected timer clock
// - comparator P checks counter bits 9..7; comparator A all ten bits
// - software alters counter only by clearing it via counter_on rise
// - counter clears on overflow or selected match, raising an interrupt
// - pause bit holds the count; counting resumes from held value
// - clock select picks sys/4, sys, high/16, high/64 or sub clock
// - counter_on low stops and keeps count; rising edge zeroes and starts
// - counter_on rise returns output to initial level in output modes
// - comparator P period is code times 128 clocks, code 0 gives 1024
// - coarse code zero lets the counter run to maximum and overflow
// - clear_select 0 makes a comparator P match clear the counter
// - mode field: 00 compare output, 10 pwm, 11 timer/counter
// - timer/counter mode leaves pin undefined; pin function ignored
// - compare mode A match: keep, drive low, drive high or toggle
// - pwm pin function: inactive, active, waveform; 11 undefined
// - match requesting the level already held leaves the pin unchanged
// - complementary pin always carries inverse of primary output
// - initial level bit sets pre-match level, or pwm active level
// - output_invert inverts primary pin except in timer/counter mode
// - clear_select 1 clears on A match instead; ignored in pwm
// - period_duty_swap chooses which comparator sets pwm period and duty
//
// Added by the designer: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module cpt_timer
(
   input  wire logic        CORE_CLK,
   input  wire logic        RSTN,
   input  wire logic        CLK_EN,
   input  wire logic        H_CLK_TICK,
   input  wire logic        SUB_CLK_TICK,
   input  wire logic [7:0]  S_AXI_AWADDR,
   input  wire logic        S_AXI_AWVALID,
   output var  logic        S_AXI_AWREADY,
   input  wire logic [31:0] S_AXI_WDATA,
   input  wire logic [3:0]  S_AXI_WSTRB,
   input  wire logic        S_AXI_WVALID,
   output var  logic        S_AXI_WREADY,
   output var  logic [1:0]  S_AXI_BRESP,
   output var  logic        S_AXI_BVALID,
   input  wire logic        S_AXI_BREADY,
   input  wire logic [7:0]  S_AXI_ARADDR,
   input  wire logic        S_AXI_ARVALID,
   output var  logic        S_AXI_ARREADY,
   output var  logic [31:0] S_AXI_RDATA,
   output var  logic [1:0]  S_AXI_RRESP,
   output var  logic        S_AXI_RVALID,
   input  wire logic        S_AXI_RREADY,
   output var  logic        TIMER_OUT,
   output var  logic        TIMER_OUT_N,
   output var  logic        CMP_A_IRQ,
   output var  logic        CMP_P_IRQ
);

   // reset synchroniser
   logic       rst_meta_n;
   logic       rstn_s;

   // registers and state
   logic [7:0] ctrl_a;
   logic [7:0] ctrl_b;
   logic [9:0] match_a;
   logic [7:0] hold_buf;
   logic [9:0] cnt;
   logic [5:0] psc;
   logic       on_prev;
   logic       out_q;

   // bus state
   logic       aw_held;
   logic       w_held;
   logic [7:0] aw_addr;
   logic [7:0] w_byte;
   logic       w_lane0;

   always_ff @(posedge CORE_CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         rst_meta_n <= 1'b0;
         rstn_s     <= 1'b0;
      end
      else
      begin
         rst_meta_n <= 1'b1;
         rstn_s     <= rst_meta_n;
      end
   end

   // control fields
   wire logic       pause_bit            = ctrl_a[cpt_pkg::CA_PAUSE];
   wire logic [2:0] clock_select         = ctrl_a[cpt_pkg::CA_CKSEL +: 3];
   wire logic       counter_on           = ctrl_a[cpt_pkg::CA_ON];
   wire logic [2:0] coarse_compare_code  = ctrl_a[cpt_pkg::CA_CODE +: 3];
   wire logic [1:0] mode_field           = ctrl_b[cpt_pkg::CB_MODE +: 2];
   wire logic [1:0] pin_function         = ctrl_b[cpt_pkg::CB_PINF +: 2];
   wire logic       output_initial_level = ctrl_b[cpt_pkg::CB_OIL];
   wire logic       output_invert        = ctrl_b[cpt_pkg::CB_INV];
   wire logic       period_duty_swap     = ctrl_b[cpt_pkg::CB_SWAP];
   wire logic       clear_select         = ctrl_b[cpt_pkg::CB_CLRSEL];

   wire logic is_pwm = (mode_field == cpt_pkg::MODE_PWM);
   wire logic is_cmp = (mode_field == cpt_pkg::MODE_CMP);
   wire logic is_tmr = (mode_field == cpt_pkg::MODE_TMR);

   // write channel handshakes
   wire logic aw_hs = S_AXI_AWVALID && S_AXI_AWREADY;
   wire logic w_hs  = S_AXI_WVALID && S_AXI_WREADY;
   wire logic do_wr = aw_held && w_held && !S_AXI_BVALID;
   wire logic b_hs  = S_AXI_BVALID && S_AXI_BREADY;
   wire logic next_aw_held = do_wr ? 1'b0 : (aw_hs ? 1'b1 : aw_held);
   wire logic next_w_held  = do_wr ? 1'b0 : (w_hs ? 1'b1 : w_held);

   wire logic wr_ok   = do_wr && w_lane0;
   wire logic wr_ca   = wr_ok && (aw_addr == cpt_pkg::ADDR_CTRL_A);
   wire logic wr_cb   = wr_ok && (aw_addr == cpt_pkg::ADDR_CTRL_B);
   wire logic wr_mlo  = wr_ok && (aw_addr == cpt_pkg::ADDR_MATCH_LOW);
   wire logic wr_mhi  = wr_ok && (aw_addr == cpt_pkg::ADDR_MATCH_HIGH);
   wire logic wr_map  = (aw_addr == cpt_pkg::ADDR_CTRL_A)
                     || (aw_addr == cpt_pkg::ADDR_CTRL_B)
                     || (aw_addr == cpt_pkg::ADDR_COUNT_LOW)
                     || (aw_addr == cpt_pkg::ADDR_COUNT_HIGH)
                     || (aw_addr == cpt_pkg::ADDR_MATCH_LOW)
                     || (aw_addr == cpt_pkg::ADDR_MATCH_HIGH);

   // read channel
   wire logic rd_hs = S_AXI_ARVALID && S_AXI_ARREADY;
   wire logic r_hs  = S_AXI_RVALID && S_AXI_RREADY;
   wire logic next_rvalid = rd_hs ? 1'b1 : (r_hs ? 1'b0 : S_AXI_RVALID);
   wire logic rd_chi = rd_hs && (S_AXI_ARADDR == cpt_pkg::ADDR_COUNT_HIGH);
   wire logic rd_mhi = rd_hs && (S_AXI_ARADDR == cpt_pkg::ADDR_MATCH_HIGH);
   wire logic rd_map = (S_AXI_ARADDR == cpt_pkg::ADDR_CTRL_A)
                    || (S_AXI_ARADDR == cpt_pkg::ADDR_CTRL_B)
                    || (S_AXI_ARADDR == cpt_pkg::ADDR_COUNT_LOW)
                    || (S_AXI_ARADDR == cpt_pkg::ADDR_COUNT_HIGH)
                    || (S_AXI_ARADDR == cpt_pkg::ADDR_MATCH_LOW)
                    || (S_AXI_ARADDR == cpt_pkg::ADDR_MATCH_HIGH);
   wire logic [7:0] rd_byte =
        (S_AXI_ARADDR == cpt_pkg::ADDR_CTRL_A)     ? ctrl_a :
        (S_AXI_ARADDR == cpt_pkg::ADDR_CTRL_B)     ? ctrl_b :
        (S_AXI_ARADDR == cpt_pkg::ADDR_COUNT_HIGH) ? {6'h00, cnt[9:8]} :
        (S_AXI_ARADDR == cpt_pkg::ADDR_MATCH_HIGH) ? {6'h00, match_a[9:8]} :
        (S_AXI_ARADDR == cpt_pkg::ADDR_COUNT_LOW)  ? hold_buf :
        (S_AXI_ARADDR == cpt_pkg::ADDR_MATCH_LOW)  ? hold_buf :
        8'h00;

   // timer clock selection
   wire logic on_rise = counter_on && !on_prev;
   wire logic run     = counter_on && !pause_bit;
   wire logic h_src   = (clock_select == cpt_pkg::CK_H_16)
                     || (clock_select == cpt_pkg::CK_H_64);
   wire logic base    = h_src ? H_CLK_TICK : 1'b1;
   wire logic [5:0] div_mask =
        (clock_select == cpt_pkg::CK_H_64)  ? cpt_pkg::DIV64_MASK :
        (clock_select == cpt_pkg::CK_H_16)  ? cpt_pkg::DIV16_MASK :
        cpt_pkg::DIV4_MASK;
   wire logic div_tick = base && ((psc & div_mask) == div_mask);
   wire logic tick =
        (clock_select == cpt_pkg::CK_SYS)   ? 1'b1 :
        (clock_select == cpt_pkg::CK_SYS_4) ? div_tick :
        h_src                               ? div_tick :
        (clock_select == cpt_pkg::CK_SUB_A) ? SUB_CLK_TICK :
        (clock_select == cpt_pkg::CK_SUB_B) ? SUB_CLK_TICK :
        1'b0;
   wire logic step = run && tick && !on_rise;

   // comparators
   wire logic [9:0] cnt_inc = cnt + 10'h001;
   wire logic p_hit = (coarse_compare_code == cpt_pkg::CODE_ZERO)
                    ? (cnt == cpt_pkg::COUNT_MAX)
                    : ((cnt_inc[9:7] == coarse_compare_code)
                       && (cnt_inc[6:0] == 7'h00));
   wire logic a_hit = (match_a != 10'h000) && (cnt_inc == match_a);
   wire logic clr_on_a = is_pwm ? period_duty_swap : clear_select;
   wire logic clr_hit  = clr_on_a ? a_hit : p_hit;
   wire logic p_flag = step && p_hit && !(clear_select && !is_pwm);
   wire logic a_flag = step && a_hit;
   wire logic [9:0] next_cnt = clr_hit ? 10'h000 : cnt_inc;

   // pwm duty decision
   wire logic duty_on = period_duty_swap
                      ? (cnt[9:7] < coarse_compare_code)
                      : (cnt < match_a);
   wire logic inactive = !output_initial_level;

   // next raw output level
   logic next_out;
   always_comb
   begin
      next_out = out_q;
      if (on_rise && !is_tmr)
      begin
         next_out = output_initial_level;
      end
      else if (is_cmp && a_flag)
      begin
         case (pin_function)
            cpt_pkg::PINF_01: next_out = 1'b0;
            cpt_pkg::PINF_10: next_out = 1'b1;
            cpt_pkg::PINF_11: next_out = !out_q;
            default:          next_out = out_q;
         endcase
      end
      else if (is_pwm && counter_on)
      begin
         case (pin_function)
            cpt_pkg::PINF_00: next_out = inactive;
            cpt_pkg::PINF_01: next_out = output_initial_level;
            cpt_pkg::PINF_10:
               next_out = duty_on ? output_initial_level : inactive;
            default:          next_out = out_q;
         endcase
      end
   end

   // pin level: inversion ignored in timer/counter mode
   wire logic pin_level = out_q ^ (output_invert && !is_tmr);

   // bus write side
   always_ff @(posedge CORE_CLK or negedge rstn_s)
   begin
      if (!rstn_s)
      begin
         aw_held       <= 1'b0;
         w_held        <= 1'b0;
         aw_addr       <= 8'h00;
         w_byte        <= 8'h00;
         w_lane0       <= 1'b0;
         S_AXI_AWREADY <= 1'b0;
         S_AXI_WREADY  <= 1'b0;
         S_AXI_BVALID  <= 1'b0;
         S_AXI_BRESP   <= cpt_pkg::RESP_OKAY;
      end
      else if (CLK_EN)
      begin
         aw_held       <= next_aw_held;
         w_held        <= next_w_held;
         S_AXI_AWREADY <= !next_aw_held;
         S_AXI_WREADY  <= !next_w_held;
         if (aw_hs)
         begin
            aw_addr <= S_AXI_AWADDR;
         end
         if (w_hs)
         begin
            w_byte  <= S_AXI_WDATA[7:0];
            w_lane0 <= S_AXI_WSTRB[0];
         end
         if (do_wr)
         begin
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP  <= wr_map ? cpt_pkg::RESP_OKAY
                                   : cpt_pkg::RESP_SLVERR;
         end
         else if (b_hs)
         begin
            S_AXI_BVALID <= 1'b0;
         end
      end
   end

   // bus read side
   always_ff @(posedge CORE_CLK or negedge rstn_s)
   begin
      if (!rstn_s)
      begin
         S_AXI_ARREADY <= 1'b0;
         S_AXI_RVALID  <= 1'b0;
         S_AXI_RDATA   <= 32'h0000_0000;
         S_AXI_RRESP   <= cpt_pkg::RESP_OKAY;
      end
      else if (CLK_EN)
      begin
         S_AXI_ARREADY <= !next_rvalid;
         S_AXI_RVALID  <= next_rvalid;
         if (rd_hs)
         begin
            S_AXI_RDATA <= {24'h00_0000, rd_byte};
            S_AXI_RRESP <= rd_map ? cpt_pkg::RESP_OKAY
                                  : cpt_pkg::RESP_SLVERR;
         end
      end
   end

   // software registers and shared holding buffer
   always_ff @(posedge CORE_CLK or negedge rstn_s)
   begin
      if (!rstn_s)
      begin
         ctrl_a   <= cpt_pkg::CTRL_A_RST;
         ctrl_b   <= cpt_pkg::CTRL_B_RST;
         match_a  <= cpt_pkg::MATCH_A_RST;
         hold_buf <= cpt_pkg::HOLD_RST;
      end
      else if (CLK_EN)
      begin
         if (wr_ca)
         begin
            ctrl_a <= w_byte;
         end
         if (wr_cb)
         begin
            ctrl_b <= w_byte;
         end
         if (wr_mhi)
         begin
            match_a <= {w_byte[1:0], hold_buf};
         end
         if (wr_mlo)
         begin
            hold_buf <= w_byte;
         end
         else if (rd_chi)
         begin
            hold_buf <= cnt[7:0];
         end
         else if (rd_mhi)
         begin
            hold_buf <= match_a[7:0];
         end
      end
   end

   // prescaler, counter and match pulses
   always_ff @(posedge CORE_CLK or negedge rstn_s)
   begin
      if (!rstn_s)
      begin
         psc       <= 6'h00;
         cnt       <= 10'h000;
         on_prev   <= 1'b0;
         CMP_A_IRQ <= 1'b0;
         CMP_P_IRQ <= 1'b0;
      end
      else if (CLK_EN)
      begin
         on_prev   <= counter_on;
         CMP_A_IRQ <= a_flag;
         CMP_P_IRQ <= p_flag;
         if (!counter_on)
         begin
            psc <= 6'h00;
         end
         else if (base && run)
         begin
            psc <= psc + 6'h01;
         end
         if (on_rise)
         begin
            cnt <= 10'h000;
         end
         else if (step)
         begin
            cnt <= next_cnt;
         end
      end
   end

   // output pins
   always_ff @(posedge CORE_CLK or negedge rstn_s)
   begin
      if (!rstn_s)
      begin
         out_q       <= 1'b0;
         TIMER_OUT   <= 1'b0;
         TIMER_OUT_N <= 1'b1;
      end
      else if (CLK_EN)
      begin
         out_q       <= next_out;
         TIMER_OUT   <= pin_level;
         TIMER_OUT_N <= !pin_level;
      end
   end

endmodule

`default_nettype wire

// >>> test/cpt_timer_props.sv
// assertion checker on the compact timer ports
`timescale 1ns/1ps
`default_nettype none
module cpt_timer_props
(
   input  wire logic        CORE_CLK,
   input  wire logic        RSTN,
   input  wire logic        S_AXI_AWVALID,
   input  wire logic        S_AXI_AWREADY,
   input  wire logic        S_AXI_WVALID,
   input  wire logic        S_AXI_WREADY,
   input  wire logic [1:0]  S_AXI_BRESP,
   input  wire logic        S_AXI_BVALID,
   input  wire logic        S_AXI_BREADY,
   input  wire logic [7:0]  S_AXI_ARADDR,
   input  wire logic        S_AXI_ARVALID,
   input  wire logic        S_AXI_ARREADY,
   input  wire logic [31:0] S_AXI_RDATA,
   input  wire logic [1:0]  S_AXI_RRESP,
   input  wire logic        S_AXI_RVALID,
   input  wire logic        S_AXI_RREADY,
   input  wire logic        TIMER_OUT,
   input  wire logic        TIMER_OUT_N,
   input  wire logic        CMP_P_IRQ
);
   default clocking cb @(posedge CORE_CLK);
   endclocking
   default disable iff (!RSTN);

   sequence wr_both_s;
      S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
   endsequence
   sequence rd_take_s;
      S_AXI_ARVALID && S_AXI_ARREADY;
   endsequence

   out_compl_a: assert property (TIMER_OUT_N == !TIMER_OUT)
      else $error("complementary pin not inverse");
   irq_p_pulse_a: assert property (CMP_P_IRQ |=> !CMP_P_IRQ [*8])
      else $error("comparator p request not a single pulse");
   bresp_hold_a: assert property
      (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
      else $error("write response dropped early");
   rdata_hold_a: assert property
      (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
      else $error("read data dropped early");
   wr_answer_a: assert property
      (wr_both_s ##0 !S_AXI_BVALID |-> ##2 S_AXI_BVALID)
      else $error("write response late");
   rd_answer_a: assert property (rd_take_s |=> S_AXI_RVALID)
      else $error("read data late");
   rd_unmapped_a: assert property
      (rd_take_s ##0 (S_AXI_ARADDR > cpt_pkg::ADDR_MATCH_HIGH) |=>
       S_AXI_RRESP == cpt_pkg::RESP_SLVERR && S_AXI_RDATA == 32'h0)
      else $error("unmapped read not refused");
   rd_block_a: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
      else $error("read address accepted while busy");
   rd_upper_a: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h0)
      else $error("upper read bits not zero");
endmodule

bind cpt_timer cpt_timer_props cpt_timer_props_i
(
   .CORE_CLK      (CORE_CLK),
   .RSTN          (RSTN),
   .S_AXI_AWVALID (S_AXI_AWVALID),
   .S_AXI_AWREADY (S_AXI_AWREADY),
   .S_AXI_WVALID  (S_AXI_WVALID),
   .S_AXI_WREADY  (S_AXI_WREADY),
   .S_AXI_BRESP   (S_AXI_BRESP),
   .S_AXI_BVALID  (S_AXI_BVALID),
   .S_AXI_BREADY  (S_AXI_BREADY),
   .S_AXI_ARADDR  (S_AXI_ARADDR),
   .S_AXI_ARVALID (S_AXI_ARVALID),
   .S_AXI_ARREADY (S_AXI_ARREADY),
   .S_AXI_RDATA   (S_AXI_RDATA),
   .S_AXI_RRESP   (S_AXI_RRESP),
   .S_AXI_RVALID  (S_AXI_RVALID),
   .S_AXI_RREADY  (S_AXI_RREADY),
   .TIMER_OUT     (TIMER_OUT),
   .TIMER_OUT_N   (TIMER_OUT_N),
   .CMP_P_IRQ     (CMP_P_IRQ)
);
`default_nettype wire

// >>> test/cpt_timer_tb_top.sv
// self-checking bench for the compact timer
`timescale 1ns/1ps
`default_nettype none
module cpt_timer_tb_top;
   logic        clk, rstn, h_tick, sub_tick, awvalid, wvalid, bready;
   logic        arvalid, rready, awready, wready, bvalid, arready, rvalid;
   logic        tout, tout_n, irq_a, irq_p, clk_en;
   logic [1:0]  bresp, rresp, wresp, rd_resp;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, rd_data, cnt;
   int          err_count, total_checks, sub_cnt;

   cpt_timer cpt_timer_i
   (
      .CORE_CLK(clk), .RSTN(rstn), .CLK_EN(clk_en), .H_CLK_TICK(h_tick),
      .SUB_CLK_TICK(sub_tick), .S_AXI_AWADDR(awaddr),
      .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
      .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid),
      .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
      .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
      .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
      .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
      .S_AXI_RREADY(rready), .TIMER_OUT(tout), .TIMER_OUT_N(tout_n),
      .CMP_A_IRQ(irq_a), .CMP_P_IRQ(irq_p)
   );

   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // high clock ticks every 2nd cycle, sub clock every 3rd
   always @(posedge clk)
   begin
      h_tick   <= ~h_tick;
      sub_cnt  <= (sub_cnt == 2) ? 0 : sub_cnt + 1;
      sub_tick <= (sub_cnt == 2);
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                      input string what);
      total_checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("wrong value %s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   task automatic final_report;
      if (err_count == 0 && total_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic hang;
      err_count++;
      final_report();
   endtask

   // response ready comes late on purpose, so the slave must hold
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      int n;
      @(posedge clk);
      awaddr  <= a;
      wdata   <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      for (n = 0; n < 99; n++)
      begin
         @(posedge clk);
         if (awready)
            awvalid <= 1'b0;
         if (wready)
            wvalid <= 1'b0;
         if (n == 2)
            bready <= 1'b1;
         if (bvalid && bready)
            break;
      end
      wresp = bresp;
      bready <= 1'b0;
      if (n == 99)
         hang();
   endtask

   task automatic rd(input logic [7:0] a);
      int n;
      @(posedge clk);
      araddr  <= a;
      arvalid <= 1'b1;
      for (n = 0; n < 99; n++)
      begin
         @(posedge clk);
         if (arready)
            arvalid <= 1'b0;
         if (n == 2)
            rready <= 1'b1;
         if (rvalid && rready)
            break;
      end
      rd_data = rdata;
      rd_resp = rresp;
      rready <= 1'b0;
      if (n == 99)
         hang();
   endtask

   task automatic rchk(input logic [7:0] a, input logic [7:0] e,
                       input string what);
      rd(a);
      chk(rd_data, {24'h0, e}, what);
   endtask

   task automatic rcount;
      rd(cpt_pkg::ADDR_COUNT_HIGH);
      cnt = {22'h0, rd_data[1:0], 8'h0};
      rd(cpt_pkg::ADDR_COUNT_LOW);
      cnt[7:0] = rd_data[7:0];
   endtask

   task automatic set_match(input logic [9:0] m);
      wr(cpt_pkg::ADDR_MATCH_LOW, m[7:0]);
      wr(cpt_pkg::ADDR_MATCH_HIGH, {6'h0, m[9:8]});
   endtask

   task automatic wait_pulse(input logic p, input int bound, output int n);
      for (n = 0; n < bound; n++)
      begin
         @(posedge clk);
         if (p ? irq_p : irq_a)
            break;
      end
   endtask

   // cycles between two pulses, 0 when none come
   task automatic gap(input logic p, input int bound, output int g);
      int n;
      wait_pulse(p, bound, n);
      wait_pulse(p, bound, g);
      g = (n == bound || g == bound) ? 0 : g + 1;
   endtask

   function automatic int a_period(input int s, input int m);
      int k[8] = '{4, 1, 32, 128, 3, 3, 0, 0};
      return k[s] * m;
   endfunction

   function automatic int p_period(input int c);
      return (c == 0) ? 1024 : 128 * c;
   endfunction

   function automatic logic cmp_level(input int pf, input logic oil);
      return (pf == 0) ? oil : (pf == 3) ? !oil : (pf == 2);
   endfunction

   function automatic int pwm_active(input int pf, input int m);
      return (pf == 0) ? 0 : (pf == 1) ? 128 : m;
   endfunction

   initial
   begin
      logic [7:0] v, a, lo, hi;
      int         g, m, i;
      {rstn, h_tick, sub_tick, awvalid, wvalid, bready} = '0;
      {arvalid, rready, awaddr, araddr, wdata} = '0;
      {sub_cnt, err_count, total_checks} = '0;
      clk_en = 1'b1;
      void'($urandom(38575));
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      repeat (4) @(posedge clk);
      rchk(cpt_pkg::ADDR_CTRL_A, cpt_pkg::CTRL_A_RST, "ctrl_a reset");
      rchk(cpt_pkg::ADDR_CTRL_B, cpt_pkg::CTRL_B_RST, "ctrl_b reset");
      rd(8'h18);
      chk(32'(rd_resp), 32'(cpt_pkg::RESP_SLVERR), "bad read resp");
      wr(8'h18, 8'hFF);
      chk(32'(wresp), 32'(cpt_pkg::RESP_SLVERR), "bad write resp");
      // timer kept off while control values change
      for (i = 0; i < 6; i++)
      begin
         a = i[0] ? cpt_pkg::ADDR_CTRL_B : cpt_pkg::ADDR_CTRL_A;
         v = 8'($urandom) & (i[0] ? 8'hFF : 8'hF7);
         wr(a, v);
         rchk(a, v, "ctrl readback");
      end
      lo = 8'($urandom);
      hi = 8'($urandom);
      set_match({hi[1:0], lo});
      wr(cpt_pkg::ADDR_MATCH_LOW, ~lo);
      rchk(cpt_pkg::ADDR_MATCH_HIGH, {6'h0, hi[1:0]}, "match high");
      rchk(cpt_pkg::ADDR_MATCH_LOW, lo, "match low");
      wr(cpt_pkg::ADDR_CTRL_A, 8'h00);
      wr(cpt_pkg::ADDR_CTRL_B, 8'h00);
      wr(cpt_pkg::ADDR_CTRL_A, 8'h98);
      rcount();
      chk(cnt, 0, "count paused");
      wr(cpt_pkg::ADDR_CTRL_A, 8'h18);
      repeat (40) @(posedge clk);
      wr(cpt_pkg::ADDR_CTRL_A, 8'h98);
      rcount();
      chk(cnt > 40, 1, "count ran");
      v = cnt[7:0];
      wr(cpt_pkg::ADDR_COUNT_HIGH, 8'h03);
      wr(cpt_pkg::ADDR_CTRL_A, 8'h90);
      rcount();
      chk(cnt[7:0], v, "count kept");
      wr(cpt_pkg::ADDR_CTRL_A, 8'h98);
      rcount();
      chk(cnt, 0, "count cleared");
      wr(cpt_pkg::ADDR_CTRL_A, 8'h00);
      wr(cpt_pkg::ADDR_CTRL_B, 8'h01);
      set_match(10'd5);
      for (i = 0; i < 8; i++)
      begin
         wr(cpt_pkg::ADDR_CTRL_A, 8'h00);
         wr(cpt_pkg::ADDR_CTRL_A, {1'b0, 3'(i), 4'h8});
         gap(1'b0, 1000, g);
         chk(g, a_period(i, 5), "clock select period");
      end
      m = 130 + $urandom_range(170);
      set_match(10'(m));
      wr(cpt_pkg::ADDR_CTRL_A, 8'h00);
      wr(cpt_pkg::ADDR_CTRL_A, 8'h19);
      gap(1'b0, 400, g);
      chk(g, m, "match a period");
      gap(1'b1, 400, g);
      chk(g, 0, "p request");
      // clock enable low for 20 cycles stretches one period by 20
      wait_pulse(1'b0, 400, g);
      clk_en <= 1'b0;
      repeat (20) @(posedge clk);
      clk_en <= 1'b1;
      wait_pulse(1'b0, 400, g);
      chk(g, m - 1, "frozen period");
      wr(cpt_pkg::ADDR_CTRL_A, 8'h00);
      wr(cpt_pkg::ADDR_CTRL_B, 8'h00);
      for (i = 0; i < 8; i++)
      begin
         wr(cpt_pkg::ADDR_CTRL_A, 8'h00);
         wr(cpt_pkg::ADDR_CTRL_A, 8'h18 | 8'(i));
         gap(1'b1, 1100, g);
         chk(g, p_period(i), "p period");
      end
      set_match(10'd40);
      for (i = 0; i < 16; i++)
      begin
         wr(cpt_pkg::ADDR_CTRL_A, 8'h00);
         wr(cpt_pkg::ADDR_CTRL_B, {2'b00, 4'(i), 2'b01});
         wr(cpt_pkg::ADDR_CTRL_A, 8'h18);
         repeat (4) @(posedge clk);
         chk(tout, i[1] ^ i[0], "pin initial");
         wait_pulse(1'b0, 100, g);
         repeat (3) @(posedge clk);
         chk(tout, cmp_level(i >> 2, i[1]) ^ i[0], "pin match");
         chk(tout_n, !tout, "pin inverse");
      end
      m = 10 + $urandom_range(90);
      set_match(10'(m));
      for (i = 0; i < 12; i++)
      begin
         wr(cpt_pkg::ADDR_CTRL_A, 8'h00);
         wr(cpt_pkg::ADDR_CTRL_B, {2'b10, 4'(i), 2'b00});
         wr(cpt_pkg::ADDR_CTRL_A, 8'h19);
         repeat (150) @(posedge clk);
         g = 0;
         repeat (128)
         begin
            @(posedge clk);
            g += int'(tout == (i[1] ^ i[0]));
         end
         chk(g, pwm_active(i >> 2, m), "pwm active");
      end
      // timer/counter mode: matches still flagged, pin left alone
      wr(cpt_pkg::ADDR_CTRL_A, 8'h00);
      wr(cpt_pkg::ADDR_CTRL_B, 8'hF5);
      wr(cpt_pkg::ADDR_CTRL_A, 8'h18);
      repeat (4) @(posedge clk);
      v[0] = tout;
      wait_pulse(1'b0, 400, g);
      chk(g < 400, 1, "timer mode match");
      repeat (3) @(posedge clk);
      chk(tout, v[0], "timer mode pin");
      final_report();
   end
endmodule
`default_nettype wire
